// ==== hw/dac_register_decode_and_trim.sv ====
// Register decode, trim and double-buffered load of the forty channels.
// Behaviour
// [R1] Forty channels, each taking 14-bit codes.
// [R2] Control bits pick reference source and level.
// [R3] Input stage separate; load pin updates all.
// [R4] Converter code from gain and offset formula.
// [R5] Each channel has own offset and gain.
// [R6] Gain defaults 0x3FFE, bit zero held low.
// [R7] Offset is 14 bits, default 0x2000.
// [R8] Select bits route word to register type.
// [R9] Input codes are straight binary.
// [R10] Offset codes are offset binary.
// [R11] Gain codes scale from zero to one.
// [R12] Select zero decodes address into command.
// [R13] Host issues commands with write low.
// [R14] Control register written or read by address.
// [R15] Clear code resets zero; clear loads converters.
// [R16] Power down keeps registers, rejects writes except power up and down.
// [R17] Soft reset restores trims, clears converters, 135us.
// [R18] Corrected code clamped to full range.
// [R19] Channel address picks written channel.
`timescale 1ns/100ps
`include "dac_trim_defines.svh"
module dac_register_decode_and_trim
    import dac_trim_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic write_strobe_in,
    input wire logic read_not_write_in,
    input wire logic register_select_high_in,
    input wire logic register_select_low_in,
    input wire logic [5:0] channel_or_command_address_in,
    input wire logic [13:0] data_word_lines_in,
    input wire logic load_outputs_pin_n_in,
    input wire logic clear_outputs_n_in,
    input wire logic power_down_pin_in,
    output logic [13:0] read_data_out,
    output logic read_valid_out,
    output logic busy_out,
    output logic powered_down_out,
    output logic internal_reference_enable_out,
    output logic reference_level_out,
    output logic [5:0] monitor_channel_out,
    output logic [`CHANNELS*14-1:0] converter_codes_out
);
    // ==========================================================
    // State
    typedef struct packed {
        code_t [`CHANNELS-1:0] input_code;
        code_t [`CHANNELS-1:0] offset_trim;
        code_t [`CHANNELS-1:0] gain_trim;
        code_t [`CHANNELS-1:0] converter;
        code_t clear_code;
        code_t control;
        logic soft_down;
        logic [5:0] monitor;
        logic [10:0] wait_count;
        ctl_state_e state;
        logic [2:0] load_sync;
        logic [2:0] clear_sync;
        logic [2:0] down_sync;
        logic load_level;
        logic clear_level;
        logic down_level;
        code_t read_data;
        logic read_valid;
        logic busy;
        logic powered_down;
    } state_s;
    typedef code_t [`CHANNELS-1:0] bank_t;
    state_s q, d;
    code_t [`CHANNELS-1:0] corrected;

    // ==========================================================
    // Correction per channel
    genvar g;
    generate
        for (g = 0; g < `CHANNELS; g++) begin : gen_ch // R1 R5
            trim_calc u_calc (
                .input_code_in(q.input_code[g]),
                .gain_in(q.gain_trim[g]),
                .offset_in(q.offset_trim[g]),
                .result_out(corrected[g])
            );
        end
    endgenerate

    // ==========================================================
    // Helpers
    function automatic bank_t fill_all(input code_t value);
        bank_t bank;
        for (int i = 0; i < `CHANNELS; i++) begin
            bank[i] = value;
        end
        return bank;
    endfunction

    // A pin level changes only once the second and third flops agree.
    function automatic logic agreed(input logic [2:0] s, input logic old);
        agreed = (s[1] == s[2]) ? s[2] : old;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic powered;
        logic [1:0] sel;
        chan_t addr;
        powered = q.soft_down | q.down_level;
        sel = {register_select_high_in, register_select_low_in};
        addr = channel_or_command_address_in;
        d = q;
        d.load_sync = {q.load_sync[1:0], ~load_outputs_pin_n_in};
        d.clear_sync = {q.clear_sync[1:0], ~clear_outputs_n_in};
        d.down_sync = {q.down_sync[1:0], power_down_pin_in};
        d.load_level = agreed(q.load_sync, q.load_level);
        d.clear_level = agreed(q.clear_sync, q.clear_level);
        d.down_level = agreed(q.down_sync, q.down_level);
        d.read_valid = 1'b0;
        if (q.load_level) begin
            d.converter = corrected; // R3 R4
        end
        // The clear pin wins over the load pin.
        if (q.clear_level) begin
            d.converter = fill_all(q.clear_code); // R15
        end
        case (q.state)
            ST_RESET: begin
                // Host strobes are ignored until the wait runs out.
                if (q.wait_count == 11'h001) begin
                    d.state = ST_IDLE;
                end
                d.wait_count = q.wait_count - 11'h001; // R17
            end
            ST_IDLE: begin
                if (write_strobe_in) begin
                    if (sel == `SEL_SPECIAL && read_not_write_in) begin
                        if (addr == `CMD_CONTROL) begin
                            d.read_data = q.control; // R14
                            d.read_valid = 1'b1;
                        end
                    end else if (sel == `SEL_SPECIAL) begin // R12 R13
                        // Power commands stay accepted while powered down.
                        case (addr)
                            `CMD_POWER_UP: d.soft_down = 1'b0;
                            `CMD_POWER_DOWN: d.soft_down = 1'b1;
                            default: begin
                            end
                        endcase
                        if (!powered) begin // R16
                            case (addr)
                                `CMD_WRITE_CLEAR: d.clear_code = data_word_lines_in;
                                `CMD_SOFT_CLEAR: d.converter = fill_all(q.clear_code); // R15
                                `CMD_CONTROL: d.control = data_word_lines_in; // R14
                                `CMD_MONITOR: d.monitor = data_word_lines_in[13:8];
                                `CMD_SOFT_RESET: begin
                                    for (int i = 0; i < `CHANNELS; i++) begin
                                        d.gain_trim[i] = `GAIN_RESET; // R17
                                        d.offset_trim[i] = `OFFSET_RESET;
                                    end
                                    d.converter = fill_all(14'h0000); // R17
                                    d.state = ST_RESET;
                                    d.wait_count = 11'(`SOFT_RESET_CYCLES); // R17
                                end
                                default: begin
                                end
                            endcase
                        end
                    end else if (!powered && !read_not_write_in
                            && addr < 6'(`CHANNELS)) begin // R16 R19
                        // Codes above the last channel never reach this point.
                        case (sel) // R8
                            `SEL_INPUT: d.input_code[addr] = data_word_lines_in; // R9
                            `SEL_OFFSET: d.offset_trim[addr] = data_word_lines_in; // R7 R10
                            `SEL_GAIN: d.gain_trim[addr] = {data_word_lines_in[13:1], 1'b0}; // R6 R11
                            default: begin
                            end
                        endcase
                    end
                end
            end
            default: d.state = ST_IDLE;
        endcase
        // Status copies are registered so that those outputs come from flops.
        d.busy = (d.state == ST_RESET);
        d.powered_down = d.soft_down | d.down_level;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= '0;
            // Trims leave reset at unity gain and zero shift.
            for (int i = 0; i < `CHANNELS; i++) begin
                q.gain_trim[i] <= `GAIN_RESET; // R6
                q.offset_trim[i] <= `OFFSET_RESET; // R7
            end
            q.clear_code <= `CLEAR_RESET; // R15
            q.control <= `CONTROL_RESET;
            q.state <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Host port outputs
    always_comb begin
        read_data_out = q.read_data;
        read_valid_out = q.read_valid;
        busy_out = q.busy; // R17
        powered_down_out = q.powered_down; // R16
    end

    // ==========================================================
    // Converter outputs
    always_comb begin
        internal_reference_enable_out = q.control[`INT_REF_BIT]; // R2
        reference_level_out = q.control[`REF_LEVEL_BIT]; // R2
        monitor_channel_out = q.monitor;
        converter_codes_out = q.converter;
    end
endmodule // dac_register_decode_and_trim

// ==== hw/dac_trim_defines.svh ====
// Offsets, codes, reset values and timing counts of the converter front end.
`ifndef DAC_TRIM_DEFINES_SVH
`define DAC_TRIM_DEFINES_SVH
`define CHANNELS 40
`define CODE_W 14
`define SEL_INPUT 2'h3
`define SEL_OFFSET 2'h2
`define SEL_GAIN 2'h1
`define SEL_SPECIAL 2'h0
`define CMD_NOP 6'h00
`define CMD_WRITE_CLEAR 6'h01
`define CMD_SOFT_CLEAR 6'h02
`define CMD_POWER_DOWN 6'h08
`define CMD_POWER_UP 6'h09
`define CMD_MONITOR 6'h0A
`define CMD_CONTROL 6'h0C
`define CMD_SOFT_RESET 6'h0F
`define GAIN_RESET 14'h3FFE
`define OFFSET_RESET 14'h2000
`define CLEAR_RESET 14'h0000
`define CONTROL_RESET 14'h2000
`define INT_REF_BIT 10
`define REF_LEVEL_BIT 12
`define CODE_MAX 16'h3FFF
`define HALF_SCALE 16'h2000
`define CLK_MHZ 10
`define SOFT_RESET_US 135
`define SOFT_RESET_CYCLES (`SOFT_RESET_US * `CLK_MHZ)
`endif

// ==== hw/dac_trim_pkg.sv ====
// Types shared by the converter front end.
package dac_trim_pkg;
    typedef logic [13:0] code_t;
    typedef logic [5:0] chan_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESET = 2'b10
    } ctl_state_e;
endpackage

// ==== hw/trim_calc.sv ====
// Gain and offset correction of one channel code with clamping.
`timescale 1ns/100ps
`include "dac_trim_defines.svh"
module trim_calc
    import dac_trim_pkg::*;
(
    input wire code_t input_code_in,
    input wire code_t gain_in,
    input wire code_t offset_in,
    output code_t result_out
);
    logic [29:0] product;
    logic signed [17:0] sum;
    always_comb begin
        product = 30'(input_code_in) * (30'(gain_in) + 30'h2); // R4
        sum = $signed({4'h0, product[27:14]}) + $signed({4'h0, offset_in})
            - $signed({2'h0, `HALF_SCALE}); // R4
        if (product[29:28] != 2'h0) begin
            result_out = 14'h3FFF; // R18
        end else if (sum < 0) begin
            result_out = 14'h0000; // R18
        end else if (sum > $signed({2'h0, `CODE_MAX})) begin
            result_out = 14'h3FFF; // R18
        end else begin
            result_out = sum[13:0];
        end
    end
endmodule // trim_calc

// ==== verif/dac_trim_monitor.sv ====
// Port assertions of the converter front end.
`timescale 1ns/100ps
`include "dac_trim_defines.svh"
module dac_trim_monitor (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic write_strobe_in,
    input wire logic read_not_write_in,
    input wire logic register_select_high_in,
    input wire logic register_select_low_in,
    input wire logic [5:0] channel_or_command_address_in,
    input wire logic [13:0] data_word_lines_in,
    input wire logic power_down_pin_in,
    input wire logic read_valid_out,
    input wire logic busy_out,
    input wire logic powered_down_out,
    input wire logic internal_reference_enable_out,
    input wire logic reference_level_out,
    input wire logic [5:0] monitor_channel_out,
    input wire logic [`CHANNELS*14-1:0] converter_codes_out
);
    // ==========================================
    // Assertions
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    wire logic [5:0] cmd = channel_or_command_address_in;
    wire logic special_command_space = write_strobe_in && !busy_out && !register_select_high_in
        && !register_select_low_in;
    wire logic cw = special_command_space && !read_not_write_in && !powered_down_out;
    a_read_answer: assert property (
        special_command_space && read_not_write_in && !powered_down_out && cmd == `CMD_CONTROL
        |=> read_valid_out) else $error("control read not answered");
    a_read_cause: assert property (
        read_valid_out |-> $past(special_command_space && read_not_write_in)) else $error("stray read");
    a_ctl_bits: assert property (
        cw && cmd == `CMD_CONTROL |=>
        internal_reference_enable_out == $past(data_word_lines_in[`INT_REF_BIT])
        && reference_level_out == $past(data_word_lines_in[`REF_LEVEL_BIT]))
        else $error("reference bits wrong");
    a_monitor_sel: assert property (
        cw && cmd == `CMD_MONITOR |=> monitor_channel_out == $past(data_word_lines_in[13:8]))
        else $error("monitor channel wrong");
    a_busy_start: assert property (
        cw && cmd == `CMD_SOFT_RESET |=> busy_out) else $error("busy not raised");
    a_busy_hold: assert property (
        $rose(busy_out) |-> busy_out[*8]) else $error("busy too short");
    a_busy_cause: assert property (
        $rose(busy_out) |-> $past(cw && cmd == `CMD_SOFT_RESET)) else $error("stray busy");
    a_reset_zero: assert property (
        $rose(busy_out) |-> ##[0:2] converter_codes_out == '0) else $error("codes not cleared");
    a_pd_enter: assert property (
        cw && cmd == `CMD_POWER_DOWN |=> powered_down_out) else $error("no power down");
    a_pd_pin: assert property (
        power_down_pin_in[*6] |-> powered_down_out) else $error("pin power down ignored");
endmodule // dac_trim_monitor
bind dac_register_decode_and_trim dac_trim_monitor mon (.*);

// ==== verif/host_port_model.sv ====
// Host model driving the converter data port.
`timescale 1ns/100ps
module host_port_model (
    input wire logic clk_in,
    output logic strobe_out,
    output logic rnw_out,
    output logic [1:0] sel_out,
    output logic [5:0] addr_out,
    output logic [13:0] data_out
);
    // ==========================================
    // Transfers
    initial begin
        {strobe_out, rnw_out, sel_out, addr_out, data_out} = '0;
    end
    task xfer(input logic r, input logic [1:0] s, input logic [5:0] a, input logic [13:0] d);
        @(posedge clk_in);
        strobe_out <= 1'b1;
        rnw_out <= r;
        sel_out <= s;
        addr_out <= a;
        data_out <= d;
        @(posedge clk_in);
        strobe_out <= 1'b0;
        addr_out <= ~a;
        data_out <= ~d;
    endtask
endmodule // host_port_model

// ==== verif/tb_dac_register_decode_and_trim.sv ====
// Self-checking bench of the converter front end.
`timescale 1ns/100ps
`include "dac_trim_defines.svh"
module tb_dac_register_decode_and_trim;
    // ==========================================
    // Signals
    logic mclk_in, nrst_in, ld_n, clr_n, pd;
    wire logic stb, rnw, rv, bsy, pdo, ire, rlv;
    wire logic [1:0] sel;
    wire logic [5:0] adr, mon;
    wire logic [13:0] dat, rd;
    wire logic [`CHANNELS*14-1:0] cc;
    int error_cnt = 0, cmp_count = 0, cyc = 0, wait_n = 0;
    dac_register_decode_and_trim dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .write_strobe_in(stb), .read_not_write_in(rnw), .register_select_high_in(sel[1]),
        .register_select_low_in(sel[0]), .channel_or_command_address_in(adr),
        .data_word_lines_in(dat), .load_outputs_pin_n_in(ld_n), .clear_outputs_n_in(clr_n),
        .power_down_pin_in(pd), .read_data_out(rd), .read_valid_out(rv), .busy_out(bsy),
        .powered_down_out(pdo), .internal_reference_enable_out(ire),
        .reference_level_out(rlv), .monitor_channel_out(mon), .converter_codes_out(cc));
    host_port_model h (.clk_in(mclk_in), .strobe_out(stb), .rnw_out(rnw), .sel_out(sel),
        .addr_out(adr), .data_out(dat));
    // ==========================================
    // Helpers
    function logic [13:0] calc(input int x, m, c);
        int v;
        v = ((x * (m + 2)) >> 14) + c - 8192;
        return 14'(v < 0 ? 0 : (v > 16383 ? 16383 : v));
    endfunction
    task chk(input logic [13:0] g, e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task cmd(input logic [5:0] a, input logic [13:0] d);
        h.xfer(1'b0, `SEL_SPECIAL, a, d);
    endtask
    task rdc(input logic [13:0] e);
        h.xfer(1'b1, `SEL_SPECIAL, `CMD_CONTROL, 14'h0000);
        @(negedge mclk_in);
        chk({13'h0000, rv}, 14'h0001);
        chk(rd, e);
    endtask
    task load;
        @(posedge mclk_in);
        ld_n <= 1'b0;
        repeat (2) @(posedge mclk_in);
        ld_n <= 1'b1;
        repeat (6) @(negedge mclk_in);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            conclude();
        end
    end
    // ==========================================
    // Tests
    initial begin
        {nrst_in, ld_n, clr_n, pd} = 4'b0110;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        rdc(`CONTROL_RESET);
        cmd(`CMD_CONTROL, 14'h1400);
        rdc(14'h1400);
        chk({12'h000, ire, rlv}, 14'h0003);
        $display("end control");
        h.xfer(1'b0, `SEL_INPUT, 6'd0, 14'h1000);
        h.xfer(1'b0, `SEL_GAIN, 6'd39, 14'h2001);
        h.xfer(1'b0, `SEL_OFFSET, 6'd39, 14'h2064);
        h.xfer(1'b0, `SEL_INPUT, 6'd39, 14'h3000);
        h.xfer(1'b0, `SEL_OFFSET, 6'd1, 14'h3FFF);
        h.xfer(1'b0, `SEL_INPUT, 6'd1, 14'h3FFF);
        h.xfer(1'b0, `SEL_OFFSET, 6'd2, 14'h0000);
        h.xfer(1'b0, `SEL_INPUT, 6'd2, 14'h0010);
        h.xfer(1'b0, `SEL_GAIN, 6'd3, 14'h0001);
        h.xfer(1'b0, `SEL_INPUT, 6'd3, 14'h3FFF);
        repeat (6) @(negedge mclk_in);
        chk(cc[39*14+:14], 14'h0000);
        load();
        chk(cc[13:0], calc(14'h1000, 14'h3FFE, 14'h2000));
        chk(cc[39*14+:14], calc(14'h3000, 14'h2000, 14'h2064));
        chk(cc[14+:14], 14'h3FFF);
        chk(cc[28+:14], 14'h0000);
        chk(cc[42+:14], calc(14'h3FFF, 14'h0000, 14'h2000));
        $display("end trim");
        cmd(`CMD_WRITE_CLEAR, 14'h0123);
        cmd(`CMD_SOFT_CLEAR, 14'h0000);
        repeat (4) @(negedge mclk_in);
        chk(cc[39*14+:14], 14'h0123);
        cmd(`CMD_WRITE_CLEAR, 14'h0456);
        @(posedge mclk_in);
        clr_n <= 1'b0;
        repeat (8) @(negedge mclk_in);
        chk(cc[20*14+:14], 14'h0456);
        @(posedge mclk_in);
        clr_n <= 1'b1;
        cmd(`CMD_MONITOR, 14'h2700);
        @(negedge mclk_in);
        chk({8'h00, mon}, 14'h0027);
        $display("end clear");
        cmd(`CMD_POWER_DOWN, 14'h0000);
        @(negedge mclk_in);
        chk({13'h0000, pdo}, 14'h0001);
        cmd(`CMD_CONTROL, 14'h0000);
        cmd(`CMD_POWER_UP, 14'h0000);
        h.xfer(1'b1, `SEL_SPECIAL, `CMD_NOP, 14'h0000);
        rdc(14'h1400);
        chk({13'h0000, pdo}, 14'h0000);
        @(posedge mclk_in);
        pd <= 1'b1;
        repeat (8) @(negedge mclk_in);
        chk({13'h0000, pdo}, 14'h0001);
        @(posedge mclk_in);
        pd <= 1'b0;
        repeat (8) @(negedge mclk_in);
        $display("end power");
        cmd(`CMD_SOFT_RESET, 14'h0000);
        @(negedge mclk_in);
        chk({13'h0000, bsy}, 14'h0001);
        wait_n = 0;
        while (bsy !== 1'b0 && wait_n < 2000) begin
            @(negedge mclk_in);
            wait_n++;
        end
        chk(14'(wait_n), 14'(`SOFT_RESET_CYCLES));
        chk(cc[39*14+:14], 14'h0000);
        load();
        chk(cc[39*14+:14], 14'h3000);
        $display("end soft reset");
        conclude();
    end
endmodule // tb_dac_register_decode_and_trim
